// ==== diag_enable_pkg.sv ====
package diag_enable_pkg;
   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] DIAG_ENABLE_OFFSET = 8'h00; // check enables
   localparam logic [7:0] ERROR_FLAGS_OFFSET = 8'h04; // sticky flags
   localparam logic [7:0] CLOCK_COUNT_OFFSET = 8'h08; // clock counter
   // ****************************************
   // enable register layout and reset
   // ****************************************
   localparam logic [23:0] DIAG_ENABLE_RESET = 24'h000040;
   localparam int MUST_BE_ZERO_BIT = 23;
   localparam int CLOCK_COUNTER_ENABLE_BIT = 22;
   localparam int CAP_CHECK_FAULT_TEST_BIT = 21;
   localparam int CAP_CHECK_SELECT_HI = 20;
   localparam int CAP_CHECK_SELECT_LO = 19;
   localparam int CAL_CHECK_ENABLE_BIT = 18;
   localparam int CONVERSION_CHECK_ENABLE_BIT = 17;
   localparam int SATURATION_CHECK_ENABLE_BIT = 16;
   localparam int POS_INPUT_OVERVOLT_ENABLE_BIT = 15;
   localparam int POS_INPUT_UNDERVOLT_ENABLE_BIT = 14;
   localparam int NEG_INPUT_OVERVOLT_ENABLE_BIT = 13;
   localparam int NEG_INPUT_UNDERVOLT_ENABLE_BIT = 12;
   localparam int REFERENCE_DETECT_ENABLE_BIT = 11;
   localparam int DIGITAL_REG_TRIP_TEST_BIT = 10;
   localparam int DIGITAL_REG_MONITOR_ENABLE_BIT = 9;
   localparam int ANALOG_REG_TRIP_TEST_BIT = 8;
   localparam int ANALOG_REG_MONITOR_ENABLE_BIT = 7;
   localparam int WRITE_IGNORE_REPORT_BIT = 6;
   // capacitor check selector codes
   localparam logic [1:0] CAP_SEL_ANALOG = 2'h1;
   localparam logic [1:0] CAP_SEL_DIGITAL = 2'h2;
   // ****************************************
   // error flag register layout
   // ****************************************
   localparam int FLAG_COUNT = 13;
   localparam int WRITE_IGNORE_FLAG = 0; // level, not sticky
   localparam int CAL_FLAG = 1;
   localparam int CONVERSION_ERROR_FLAG = 2;
   localparam int SATURATION_FLAG = 3;
   localparam int INPUT_FLAG_LO = 4; // neg uv, neg ov, pos uv, pos ov
   localparam int REFERENCE_FLAG = 8;
   localparam int DIGITAL_REG_ERROR_FLAG = 9;
   localparam int ANALOG_REG_ERROR_FLAG = 10;
   localparam int CAP_ANALOG_FAIL_FLAG = 11;
   localparam int CAP_DIGITAL_FAIL_FLAG = 12;
   // ****************************************
   // timing counts: capacitor check in hclk cycles, prescale in counted clock pulses
   // ****************************************
   localparam int CAP_CHECK_CYCLES = 64; // length of one capacitor check
   localparam int CLOCK_PRESCALE = 131; // counted clock pulses per step
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   typedef enum logic {CAP_IDLE, CAP_RUN} cap_state_type;
endpackage

// ==== diagnostic_check_enables.sv ====
`timescale 1ns/100ps
`default_nettype none
module diagnostic_check_enables
   import diag_enable_pkg::*;
#(
   parameter int CAP_CYCLES = CAP_CHECK_CYCLES,
   parameter int PRESCALE = CLOCK_PRESCALE
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic integrity_busy,
   input wire logic cal_fail,
   input wire logic conversion_fail,
   input wire logic saturation_detect,
   input wire logic [3:0] input_fault,
   input wire logic reference_low,
   input wire logic digital_reg_out_of_range,
   input wire logic analog_reg_out_of_range,
   input wire logic cap_absent,
   input wire logic clock_source_external,
   input wire logic external_clock,
   input wire logic oscillator_clock,
   output logic cap_disconnect,
   output logic cap_check_analog,
   output logic cap_check_digital,
   output logic digital_monitor_ground,
   output logic analog_monitor_negative_supply,
   output logic [3:0] input_monitor_enable,
   output logic reference_detect_on,
   output logic writes_refused
);
   // ****************************************
   // input synchronisers
   // ****************************************
   localparam int SYNC_W = 14;
   wire logic [SYNC_W-1:0] raw_in; // pin levels
   logic [SYNC_W-1:0] sync1_reg; // first stage only
   logic [SYNC_W-1:0] sync2_reg; // safe copy
   assign raw_in = {oscillator_clock, external_clock, clock_source_external,
                    cap_absent, analog_reg_out_of_range, digital_reg_out_of_range,
                    reference_low, input_fault, saturation_detect, conversion_fail,
                    cal_fail};
   // two flops ahead of any logic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= raw_in;
         sync2_reg <= sync1_reg;
      end
   end
   wire logic cal_s = sync2_reg[0];
   wire logic conv_s = sync2_reg[1];
   wire logic sat_s = sync2_reg[2];
   wire logic [3:0] infault_s = sync2_reg[6:3];
   wire logic ref_s = sync2_reg[7];
   wire logic dreg_s = sync2_reg[8];
   wire logic areg_s = sync2_reg[9];
   wire logic cap_absent_s = sync2_reg[10];
   wire logic ext_sel_s = sync2_reg[11];
   wire logic ext_clk_s = sync2_reg[12];
   wire logic osc_clk_s = sync2_reg[13];

   // ****************************************
   // bus slave, one wait state per transfer
   // ****************************************
   logic pend_reg; // data phase in progress
   logic pend_write_reg; // pending transfer is a word write
   logic [7:0] pend_addr_reg; // latched offset
   logic [23:0] diag_reg; // enable register
   logic [FLAG_COUNT-1:0] flags_reg; // error flags
   logic [7:0] count_reg; // clock count
   logic busy_reg; // delayed integrity busy
   wire logic take = hsel & htrans[1] & hready; // address phase accepted
   wire logic refuse = integrity_busy | busy_reg;
   wire logic wr_ok = pend_reg & pend_write_reg & ~refuse;
   wire logic wr_diag = wr_ok & (pend_addr_reg == DIAG_ENABLE_OFFSET);
   wire logic wr_flags = wr_ok & (pend_addr_reg == ERROR_FLAGS_OFFSET);
   wire logic [31:0] rd_mux =
      (pend_addr_reg == DIAG_ENABLE_OFFSET) ? {8'h00, diag_reg} :
      (pend_addr_reg == ERROR_FLAGS_OFFSET) ? {19'h00000, flags_reg} :
      (pend_addr_reg == CLOCK_COUNT_OFFSET) ? {24'h000000, count_reg} :
      32'h00000000; // unmapped reads zero
   // address capture and ready
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_reg <= 1'b0;
         pend_write_reg <= 1'b0;
         pend_addr_reg <= 8'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
      end else begin
         pend_reg <= take & ~pend_reg;
         hreadyout <= ~(take & ~pend_reg);
         hresp <= 1'b0; // always okay
         if (take & ~pend_reg) begin
            pend_write_reg <= hwrite & (hsize == HSIZE_WORD) & (haddr[31:8] == 24'h000000);
            pend_addr_reg <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
         end
         if (pend_reg) begin
            hrdata <= rd_mux;
         end
      end
   end

   // ****************************************
   // capacitor check sequencer
   // ****************************************
   cap_state_type cap_state_reg;
   logic [15:0] cap_cnt_reg; // cycles left
   logic cap_digital_reg; // which supply is under test
   wire logic [1:0] cap_sel = diag_reg[CAP_CHECK_SELECT_HI:CAP_CHECK_SELECT_LO];
   wire logic cap_req = (cap_sel == CAP_SEL_ANALOG) | (cap_sel == CAP_SEL_DIGITAL);
   wire logic cap_done = (cap_state_reg == CAP_RUN) & (cap_cnt_reg == 16'h0000);
   // forced disconnect reports as absent capacitor
   wire logic cap_fail = cap_absent_s | diag_reg[CAP_CHECK_FAULT_TEST_BIT];
   // idle until a valid code, then time the check
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cap_state_reg <= CAP_IDLE;
         cap_cnt_reg <= 16'h0000;
         cap_digital_reg <= 1'b0;
      end else begin
         case (cap_state_reg)
            CAP_IDLE: begin
               if (cap_req) begin
                  cap_state_reg <= CAP_RUN;
                  cap_cnt_reg <= 16'(CAP_CYCLES - 1);
                  cap_digital_reg <= (cap_sel == CAP_SEL_DIGITAL);
               end
            end
            CAP_RUN: begin
               if (cap_done) begin
                  cap_state_reg <= CAP_IDLE;
               end else begin
                  cap_cnt_reg <= cap_cnt_reg - 16'h0001;
               end
            end
            default: cap_state_reg <= CAP_IDLE;
         endcase
      end
   end

   // ****************************************
   // enable register
   // ****************************************
   logic [23:0] diag_next;
   // software write, then hardware clear of selector
   always_comb begin
      diag_next = diag_reg;
      if (wr_diag) begin
         diag_next = {1'b0, hwdata[22:0]}; // top bit kept at zero
      end
      if (cap_done) begin
         diag_next[CAP_CHECK_SELECT_HI:CAP_CHECK_SELECT_LO] = 2'h0;
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         diag_reg <= DIAG_ENABLE_RESET;
      end else begin
         diag_reg <= diag_next;
      end
   end

   // ****************************************
   // error flags, set wins over clear
   // ****************************************
   logic [FLAG_COUNT-1:0] flag_set; // hardware events
   logic [FLAG_COUNT-1:0] flag_clr; // software write-one-to-clear
   always_comb begin
      flag_set = '0;
      flag_set[CAL_FLAG] = diag_reg[CAL_CHECK_ENABLE_BIT] & cal_s;
      flag_set[CONVERSION_ERROR_FLAG] = diag_reg[CONVERSION_CHECK_ENABLE_BIT] & conv_s;
      flag_set[SATURATION_FLAG] = diag_reg[SATURATION_CHECK_ENABLE_BIT] & sat_s;
      flag_set[INPUT_FLAG_LO +: 4] = diag_reg[NEG_INPUT_UNDERVOLT_ENABLE_BIT +: 4] & infault_s;
      flag_set[REFERENCE_FLAG] = diag_reg[REFERENCE_DETECT_ENABLE_BIT] & ref_s;
      flag_set[DIGITAL_REG_ERROR_FLAG] = diag_reg[DIGITAL_REG_MONITOR_ENABLE_BIT]
         & (dreg_s | diag_reg[DIGITAL_REG_TRIP_TEST_BIT]);
      flag_set[ANALOG_REG_ERROR_FLAG] = diag_reg[ANALOG_REG_MONITOR_ENABLE_BIT]
         & (areg_s | diag_reg[ANALOG_REG_TRIP_TEST_BIT]);
      flag_set[CAP_ANALOG_FAIL_FLAG] = cap_done & ~cap_digital_reg & cap_fail;
      flag_set[CAP_DIGITAL_FAIL_FLAG] = cap_done & cap_digital_reg & cap_fail;
      flag_clr = wr_flags ? hwdata[FLAG_COUNT-1:0] : '0;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_reg <= '0;
         busy_reg <= 1'b0;
      end else begin
         flags_reg[FLAG_COUNT-1:1] <= (flags_reg[FLAG_COUNT-1:1] & ~flag_clr[FLAG_COUNT-1:1])
            | flag_set[FLAG_COUNT-1:1];
         // ignore flag follows the running check
         flags_reg[WRITE_IGNORE_FLAG] <= integrity_busy & diag_reg[WRITE_IGNORE_REPORT_BIT];
         busy_reg <= integrity_busy;
      end
   end

   // ****************************************
   // master clock counter
   // ****************************************
   logic clk_prev_reg; // last sampled level
   logic [7:0] pre_reg; // prescaler
   wire logic clk_sel = ext_sel_s ? ext_clk_s : osc_clk_s;
   wire logic clk_edge = clk_sel & ~clk_prev_reg;
   wire logic pre_wrap = (pre_reg == 8'(PRESCALE - 1));
   // steps once per prescale pulses, wraps at 255
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         clk_prev_reg <= 1'b0;
         pre_reg <= 8'h00;
         count_reg <= 8'h00;
      end else begin
         clk_prev_reg <= clk_sel;
         if (diag_reg[CLOCK_COUNTER_ENABLE_BIT] & clk_edge) begin
            pre_reg <= pre_wrap ? 8'h00 : pre_reg + 8'h01;
            if (pre_wrap) begin
               count_reg <= count_reg + 8'h01;
            end
         end
      end
   end

   // ****************************************
   // analog control outputs
   // ****************************************
   assign cap_disconnect = diag_reg[CAP_CHECK_FAULT_TEST_BIT];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cap_check_analog <= 1'b0;
         cap_check_digital <= 1'b0;
      end else begin
         cap_check_analog <= (cap_state_reg == CAP_IDLE) ? (cap_sel == CAP_SEL_ANALOG) & cap_req
            : ~cap_digital_reg & ~cap_done;
         cap_check_digital <= (cap_state_reg == CAP_IDLE) ? (cap_sel == CAP_SEL_DIGITAL)
            : cap_digital_reg & ~cap_done;
      end
   end
   assign digital_monitor_ground = diag_reg[DIGITAL_REG_TRIP_TEST_BIT];
   assign analog_monitor_negative_supply = diag_reg[ANALOG_REG_TRIP_TEST_BIT];
   assign input_monitor_enable = diag_reg[NEG_INPUT_UNDERVOLT_ENABLE_BIT +: 4];
   assign reference_detect_on = diag_reg[REFERENCE_DETECT_ENABLE_BIT];
   assign writes_refused = flags_reg[WRITE_IGNORE_FLAG];

   // ****************************************
   // assertions
   // ****************************************
   sequence cap_run_s;
      cap_state_reg == CAP_RUN && cap_cnt_reg == 16'h0000;
   endsequence
   sequence cap_cleared_s;
      cap_sel == 2'h0 && cap_state_reg == CAP_IDLE;
   endsequence
   top_bit_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
      diag_reg[MUST_BE_ZERO_BIT] == 1'b0) else $error("enable bit 23 not zero");
   count_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
      diag_reg[CLOCK_COUNTER_ENABLE_BIT] && clk_edge && pre_wrap |=> count_reg == $past(count_reg) + 8'h01)
      else $error("clock count did not step");
   count_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !diag_reg[CLOCK_COUNTER_ENABLE_BIT] |=> $stable(count_reg)) else $error("count moved while off");
   cap_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cap_run_s |=> cap_cleared_s) else $error("selector not cleared after check");
   cap_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
      cap_state_reg == CAP_IDLE && cap_sel == CAP_SEL_ANALOG |=> cap_check_analog && !cap_check_digital)
      else $error("analog capacitor check not started");
   conv_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      diag_reg[CONVERSION_CHECK_ENABLE_BIT] && conv_s |=> flags_reg[CONVERSION_ERROR_FLAG])
      else $error("conversion failure not flagged");
   flag_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(flags_reg[SATURATION_FLAG]) |-> $past(diag_reg[SATURATION_CHECK_ENABLE_BIT]))
      else $error("saturation flag set while disabled");
   ignore_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      integrity_busy && diag_reg[WRITE_IGNORE_REPORT_BIT] |=> writes_refused ##1 !busy_reg || writes_refused)
      else $error("write ignore flag not tracking check");
   write_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pend_reg && refuse && !cap_done |=> $stable(diag_reg)) else $error("write taken during check");
   trip_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
      diag_reg[DIGITAL_REG_TRIP_TEST_BIT] && diag_reg[DIGITAL_REG_MONITOR_ENABLE_BIT]
      |=> flags_reg[DIGITAL_REG_ERROR_FLAG]) else $error("digital trip test did not flag");
endmodule
`default_nettype wire

// ==== tb_diagnostic_check_enables.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_diagnostic_check_enables;
   import diag_enable_pkg::*;
   // ****************************************
   // signals and shortened counts
   // ****************************************
   localparam int CAPC = 4; // short capacitor check
   localparam int PRE = 2; // short clock prescaler
   localparam logic [23:0] EN_TAB [12] = '{24'h040000, 24'h020000, 24'h010000, 24'h008000, 24'h004000,
      24'h002000, 24'h001000, 24'h000800, 24'h000200, 24'h000080, 24'h000600, 24'h000180};
   localparam int FLAG_TAB [12] = '{1, 2, 3, 7, 6, 5, 4, 8, 9, 10, 9, 10}; // flag set by each entry
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, cap_disconnect, cap_check_analog, cap_check_digital;
   logic digital_monitor_ground, analog_monitor_negative_supply, reference_detect_on, writes_refused;
   logic [31:0] hrdata;
   logic [3:0] input_monitor_enable;
   logic integrity_busy = 1'b0;
   logic [9:0] fault_vec = 10'h0; // same order as the enable table
   logic clock_source_external = 1'b0;
   logic external_clock = 1'b0;
   logic oscillator_clock = 1'b0;
   logic cap_absent = 1'b0; // capacitor missing at the pin
   logic [31:0] exp_q [$]; // expected read data, oldest first
   logic rd_wait = 1'b0; // a read data phase is open
   logic [31:0] d, e;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   diagnostic_check_enables #(.CAP_CYCLES(CAPC), .PRESCALE(PRE)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .integrity_busy(integrity_busy), .cal_fail(fault_vec[0]), .conversion_fail(fault_vec[1]),
      .saturation_detect(fault_vec[2]), .input_fault({fault_vec[3], fault_vec[4], fault_vec[5], fault_vec[6]}),
      .reference_low(fault_vec[7]), .digital_reg_out_of_range(fault_vec[8]),
      .analog_reg_out_of_range(fault_vec[9]), .cap_absent(cap_absent),
      .clock_source_external(clock_source_external), .external_clock(external_clock),
      .oscillator_clock(oscillator_clock), .cap_disconnect(cap_disconnect), .cap_check_analog(cap_check_analog),
      .cap_check_digital(cap_check_digital), .digital_monitor_ground(digital_monitor_ground),
      .analog_monitor_negative_supply(analog_monitor_negative_supply), .input_monitor_enable(input_monitor_enable),
      .reference_detect_on(reference_detect_on), .writes_refused(writes_refused));
   // ****************************************
   // clock, compare and bus tasks
   // ****************************************
   initial begin
      forever #10 hclk = ~hclk;
   end
   // one comparison, counted
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // single word transfer, waits for the slave each phase
   task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= addr;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= data;
      rd_wait <= !wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
   endtask
   // read with expected value noted first
   task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
      exp_q.push_back(exp);
      xfer(1'b0, addr, 32'h0);
   endtask
   // pulse the two counted clocks, 4 cycles high and 4 low
   task automatic run_clk(input int n_ext, input int n_osc);
      for (int k = 0; k < 24; k++) begin
         external_clock <= (k % 2 == 0) && (k / 2 < n_ext);
         oscillator_clock <= (k % 2 == 0) && (k / 2 < n_osc);
         repeat (4) @(posedge hclk);
      end
   endtask
   // verdict and end of run
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ****************************************
   // watcher of read completions and timeout
   // ****************************************
   always @(posedge hclk) begin
      cycles++;
      if (rd_wait && hreadyout) begin
         check("read data", exp_q.pop_front(), hrdata);
         check("response", 32'h0, {31'h0, hresp});
         rd_wait <= 1'b0;
      end
      if (cycles == 20000) begin
         mismatches++;
         $display("BAD cycle limit expected finish seen hang");
         end_of_test();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      d = $urandom(32'hD382);
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(32'h0, 32'h40);
      rd(32'h8, 32'h0);
      $display("reset values done");
      // random enables, top bit kept clear, no capacitor check
      for (int i = 0; i < 6; i++) begin
         d = $urandom;
         d[23] = 1'b0;
         d[20:19] = 2'h0;
         e = {9'h0, d[22:0]};
         xfer(1'b1, 32'h0, d);
         rd(32'h0, e);
         check("direct outputs", {24'h0, e[21], e[15:12], e[11], e[10], e[8]}, {24'h0, cap_disconnect,
            input_monitor_enable, reference_detect_on, digital_monitor_ground, analog_monitor_negative_supply});
      end
      xfer(1'b1, 32'h0, 32'h0);
      xfer(1'b1, 32'h4, 32'h1FFE);
      $display("random enables done");
      // capacitor checks: analog with capacitor missing, digital with forced fault, idle code 11
      cap_absent <= 1'b1;
      xfer(1'b1, 32'h0, 32'h080000);
      repeat (2) @(posedge hclk);
      check("check running", 32'h1, {30'h0, cap_check_digital, cap_check_analog});
      repeat (CAPC + 4) @(posedge hclk);
      rd(32'h0, 32'h0);
      rd(32'h4, 32'h800);
      cap_absent <= 1'b0;
      xfer(1'b1, 32'h0, 32'h300000);
      repeat (2) @(posedge hclk);
      check("check running", 32'h2, {30'h0, cap_check_digital, cap_check_analog});
      repeat (CAPC + 4) @(posedge hclk);
      rd(32'h0, 32'h200000);
      rd(32'h4, 32'h1800);
      xfer(1'b1, 32'h0, 32'h180000);
      repeat (2) @(posedge hclk);
      check("check idle", 32'h0, {30'h0, cap_check_digital, cap_check_analog});
      xfer(1'b1, 32'h0, 32'h0);
      xfer(1'b1, 32'h4, 32'h1FFE);
      $display("capacitor checks done");
      // each check off then on, with its cause present
      for (int i = 0; i < 12; i++) begin
         for (int on = 0; on < 2; on++) begin
            xfer(1'b1, 32'h0, (on == 1) ? {8'h0, EN_TAB[i]} : 32'h0);
            if (i < 10) fault_vec[i] <= 1'b1;
            repeat (6) @(posedge hclk);
            fault_vec <= 10'h0;
            repeat (4) @(posedge hclk);
            rd(32'h4, (on == 1) ? 32'h1 << FLAG_TAB[i] : 32'h0);
            xfer(1'b1, 32'h0, 32'h0);
            xfer(1'b1, 32'h4, 32'h1FFE);
         end
      end
      $display("check enables done");
      // writes refused during integrity check, with and without report
      xfer(1'b1, 32'h0, 32'h40);
      integrity_busy <= 1'b1;
      repeat (3) @(posedge hclk);
      check("refused output", 32'h1, {31'h0, writes_refused});
      rd(32'h4, 32'h1);
      xfer(1'b1, 32'h0, 32'h800);
      rd(32'h0, 32'h40);
      integrity_busy <= 1'b0;
      repeat (3) @(posedge hclk);
      rd(32'h4, 32'h0);
      xfer(1'b1, 32'h0, 32'h800);
      rd(32'h0, 32'h800);
      integrity_busy <= 1'b1;
      repeat (3) @(posedge hclk);
      rd(32'h4, 32'h0);
      xfer(1'b1, 32'h0, 32'h0);
      rd(32'h0, 32'h800);
      integrity_busy <= 1'b0;
      repeat (3) @(posedge hclk);
      $display("write refusal done");
      // clock counter follows the selected source, holds when off
      xfer(1'b1, 32'h0, 32'h400000);
      clock_source_external <= 1'b1;
      repeat (4) @(posedge hclk);
      run_clk(10, 0);
      rd(32'h8, 32'h5);
      clock_source_external <= 1'b0;
      repeat (4) @(posedge hclk);
      run_clk(4, 6);
      rd(32'h8, 32'h8);
      xfer(1'b1, 32'h0, 32'h0);
      run_clk(6, 6);
      rd(32'h8, 32'h8);
      $display("clock counter done");
      // unmapped place reads zero and takes no write
      xfer(1'b1, 32'h100, 32'hFFFFFF);
      rd(32'h100, 32'h0);
      rd(32'h0, 32'h0);
      $display("unmapped access done");
      end_of_test();
   end
endmodule
`default_nettype wire
